// ### core/dctc_top.sv
// dual cascadable 8-bit timer: registers, prescaler, counters and match events
//
// Notes on behaviour
// - each counter has a control register, an 8-bit period and an 8-bit width register
// - source code picks a prescaled high clock tap, low clock, high clock or pin
// - run bit low halts and clears the count; high starts counting
// - upper mode decodes only bit 2: values 4 to 7 cascade, 0 to 3 all run as 8-bit timers
// - cascaded: source from lower select, run and preset from upper control
// - a start write may load new mode and source at once; the flip-flop keeps the old preset until a stop
// - cascaded high byte counts on the low byte's overflow
// - timer mode: count equal to period raises event, clears count, keeps counting
`timescale 1ns/1ps
`default_nettype none
module dctc_top
	import dctc_pkg::*;
#(
	parameter int DATA_W = 8
)(
	input  wire logic              clock_in,
	input  wire logic              resetn_in,
	input  wire logic [DCTC_AW-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              write_in,
	input  wire logic              read_in,
	output logic [DATA_W-1:0]      rdata_out,
	input  wire logic              low_clock_in,
	input  wire logic              lower_pin_in,
	input  wire logic              upper_pin_in,
	input  wire logic              divider_option_bit_in,
	input  wire logic              slow_mode_in,
	output logic                   lower_match_out,
	output logic                   upper_match_out,
	output logic                   lower_flipflop_out,
	output logic                   upper_flipflop_out,
	output logic [DATA_W-1:0]      lower_count_out,
	output logic [DATA_W-1:0]      upper_count_out
);
	logic [DATA_W-1:0] lower_ctrl_reg, upper_ctrl_reg;
	logic [DATA_W-1:0] lower_period_compare_reg, lower_pulse_width_reg;
	logic [DATA_W-1:0] upper_period_compare_reg, upper_pulse_width_reg;
	logic [DATA_W-1:0] lower_cnt_reg, lower_cnt_next, upper_cnt_reg, upper_cnt_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DCTC_PRE_W-1:0] pre_reg;
	logic [DCTC_LOW_PRE_W-1:0] low_pre_reg;
	logic [2:0] low_sync_reg, lpin_sync_reg, upin_sync_reg;
	logic low_prev_reg, lpin_prev_reg, upin_prev_reg;
	logic lower_ff_reg, upper_ff_reg, lower_match_reg, upper_match_reg;
	logic lower_match_flag_reg, upper_match_flag_reg;

	// three-stage sampling; a change counts once stages two and three agree
	wire low_level   = (low_sync_reg[1] == low_sync_reg[2]) ? low_sync_reg[2] : low_prev_reg;
	wire lpin_level  = (lpin_sync_reg[1] == lpin_sync_reg[2]) ? lpin_sync_reg[2] : lpin_prev_reg;
	wire upin_level  = (upin_sync_reg[1] == upin_sync_reg[2]) ? upin_sync_reg[2] : upin_prev_reg;
	wire low_tick    = low_level & ~low_prev_reg;
	wire lpin_tick   = lpin_level & ~lpin_prev_reg;
	wire upin_tick   = upin_level & ~upin_prev_reg;
	wire low_d8_tick = low_tick & (&low_pre_reg);

	// prescaler carry pulses: bit i toggles 1->0 every 2^(i+1) cycles
	logic [DCTC_PRE_W-1:0] hi_tick;
	genvar gi;
	generate
		for (gi = 0; gi < DCTC_PRE_W; gi++) begin : g_tap
			assign hi_tick[gi] = &pre_reg[gi:0];
		end
	endgenerate
	wire slow_tap = (divider_option_bit_in | slow_mode_in) ? low_d8_tick
		: hi_tick[DCTC_TAP_D2048];

	// field views
	wire [2:0] lower_mode = lower_ctrl_reg[DCTC_MODE_HI:DCTC_MODE_LO];
	wire [2:0] upper_mode = upper_ctrl_reg[DCTC_MODE_HI:DCTC_MODE_LO];
	wire cascade = upper_mode[DCTC_MODE16_BIT];
	wire lower_run = cascade ? upper_ctrl_reg[DCTC_RUN_BIT] : lower_ctrl_reg[DCTC_RUN_BIT];
	wire upper_run = upper_ctrl_reg[DCTC_RUN_BIT];

	logic lower_src_tick, upper_src_tick;
	dctc_tick_sel u_lower_sel (
		.sel_in      (lower_ctrl_reg[DCTC_SRC_HI:DCTC_SRC_LO]),
		.slow_tap_in (slow_tap),
		.hi_tick_in  (hi_tick),
		.low_tick_in (low_tick),
		.pin_tick_in (lpin_tick),
		.tick_out    (lower_src_tick)
	);
	dctc_tick_sel u_upper_sel (
		.sel_in      (upper_ctrl_reg[DCTC_SRC_HI:DCTC_SRC_LO]),
		.slow_tap_in (slow_tap),
		.hi_tick_in  (hi_tick),
		.low_tick_in (low_tick),
		.pin_tick_in (upin_tick),
		.tick_out    (upper_src_tick)
	);

	// 16-bit match compares the pair; 8-bit match compares each byte
	wire [2*DATA_W-1:0] cnt16    = {upper_cnt_reg, lower_cnt_reg};
	wire [2*DATA_W-1:0] period16 = {upper_period_compare_reg, lower_period_compare_reg};
	wire match16 = cascade && lower_run && lower_src_tick && (cnt16 == period16);
	wire lower_match = !cascade && lower_run && lower_src_tick
		&& (lower_cnt_reg == lower_period_compare_reg);
	wire upper_match = !cascade && upper_run && upper_src_tick
		&& (upper_cnt_reg == upper_period_compare_reg);
	wire lower_ovf = lower_src_tick && (&lower_cnt_reg);
	wire upper_tick = cascade ? (lower_run && lower_ovf) : upper_src_tick;

	always_comb begin
		lower_cnt_next = lower_cnt_reg;
		if (!lower_run) begin
			lower_cnt_next = '0;
		end else if (lower_match || match16) begin
			lower_cnt_next = '0;
		end else if (lower_src_tick) begin
			lower_cnt_next = lower_cnt_reg + 1'b1;
		end
	end
	always_comb begin
		upper_cnt_next = upper_cnt_reg;
		if (!upper_run) begin
			upper_cnt_next = '0;
		end else if (upper_match || match16) begin
			upper_cnt_next = '0;
		end else if (upper_tick) begin
			upper_cnt_next = upper_cnt_reg + 1'b1;
		end
	end

	// register decode and writes
	wire wr_lc = write_in && (addr_in == DCTC_LOWER_CTRL_ADDR);
	wire wr_uc = write_in && (addr_in == DCTC_UPPER_CTRL_ADDR);
	wire wr_lp = write_in && (addr_in == DCTC_LOWER_PERIOD_ADDR);
	wire wr_lw = write_in && (addr_in == DCTC_LOWER_WIDTH_ADDR);
	wire wr_up = write_in && (addr_in == DCTC_UPPER_PERIOD_ADDR);
	wire wr_uw = write_in && (addr_in == DCTC_UPPER_WIDTH_ADDR);
	wire rd_st = read_in && (addr_in == DCTC_STATUS_ADDR);
	wire [DATA_W-1:0] status = {{(DATA_W-4){1'b0}}, upper_ff_reg, lower_ff_reg,
		upper_match_flag_reg, lower_match_flag_reg};
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		case (addr_in)
			DCTC_LOWER_CTRL_ADDR:   rd_mux = lower_ctrl_reg;
			DCTC_UPPER_CTRL_ADDR:   rd_mux = upper_ctrl_reg;
			DCTC_LOWER_PERIOD_ADDR: rd_mux = lower_period_compare_reg;
			DCTC_LOWER_WIDTH_ADDR:  rd_mux = lower_pulse_width_reg;
			DCTC_UPPER_PERIOD_ADDR: rd_mux = upper_period_compare_reg;
			DCTC_UPPER_WIDTH_ADDR:  rd_mux = upper_pulse_width_reg;
			DCTC_STATUS_ADDR:       rd_mux = status;
			default:                rd_mux = '0;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			lower_ctrl_reg <= DCTC_CTRL_RESET;
			upper_ctrl_reg <= DCTC_CTRL_RESET;
			lower_period_compare_reg <= DCTC_PERIOD_RESET;
			upper_period_compare_reg <= DCTC_PERIOD_RESET;
			lower_pulse_width_reg <= DCTC_WIDTH_RESET;
			upper_pulse_width_reg <= DCTC_WIDTH_RESET;
			rdata_reg <= '0;
		end else begin
			// whole-byte writes: start write may carry new fields
			if (wr_lc) lower_ctrl_reg <= wdata_in;
			if (wr_uc) upper_ctrl_reg <= wdata_in;
			if (wr_lp) lower_period_compare_reg <= wdata_in;
			if (wr_lw) lower_pulse_width_reg <= wdata_in;
			if (wr_up) upper_period_compare_reg <= wdata_in;
			if (wr_uw) upper_pulse_width_reg <= wdata_in;
			rdata_reg <= read_in ? rd_mux : '0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			pre_reg <= '0;
			low_pre_reg <= '0;
			low_sync_reg <= '0;
			lpin_sync_reg <= '0;
			upin_sync_reg <= '0;
			low_prev_reg <= 1'b0;
			lpin_prev_reg <= 1'b0;
			upin_prev_reg <= 1'b0;
		end else begin
			pre_reg <= pre_reg + 1'b1;
			if (low_tick) low_pre_reg <= low_pre_reg + 1'b1;
			low_sync_reg <= {low_sync_reg[1:0], low_clock_in};
			lpin_sync_reg <= {lpin_sync_reg[1:0], lower_pin_in};
			upin_sync_reg <= {upin_sync_reg[1:0], upper_pin_in};
			low_prev_reg <= low_level;
			lpin_prev_reg <= lpin_level;
			upin_prev_reg <= upin_level;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			lower_cnt_reg <= '0;
			upper_cnt_reg <= '0;
			lower_ff_reg <= 1'b0;
			upper_ff_reg <= 1'b0;
			lower_match_reg <= 1'b0;
			upper_match_reg <= 1'b0;
			lower_match_flag_reg <= 1'b0;
			upper_match_flag_reg <= 1'b0;
		end else begin
			lower_cnt_reg <= lower_cnt_next;
			upper_cnt_reg <= upper_cnt_next;
			// preset follows the controlling register while stopped
			if (!lower_run) lower_ff_reg <= cascade ? upper_ctrl_reg[DCTC_FF_BIT]
				: lower_ctrl_reg[DCTC_FF_BIT];
			if (!upper_run) upper_ff_reg <= upper_ctrl_reg[DCTC_FF_BIT];
			lower_match_reg <= lower_match;
			upper_match_reg <= upper_match || match16;
			// set wins over the read-clear
			lower_match_flag_reg <= lower_match || (lower_match_flag_reg && !rd_st);
			upper_match_flag_reg <= upper_match || match16 || (upper_match_flag_reg && !rd_st);
		end
	end

	assign rdata_out = rdata_reg;
	assign lower_match_out = lower_match_reg;
	assign upper_match_out = upper_match_reg;
	assign lower_flipflop_out = lower_ff_reg;
	assign upper_flipflop_out = upper_ff_reg;
	assign lower_count_out = lower_cnt_reg;
	assign upper_count_out = upper_cnt_reg;
endmodule
`default_nettype wire

// ### core/dctc_pkg.sv
// package: register map, field layout, mode and source encodings for the dual timer
package dctc_pkg;
	localparam int DCTC_AW = 8;
	localparam logic [7:0] DCTC_LOWER_CTRL_ADDR  = 8'h16;
	localparam logic [7:0] DCTC_UPPER_CTRL_ADDR  = 8'h17;
	localparam logic [7:0] DCTC_LOWER_PERIOD_ADDR = 8'h18;
	localparam logic [7:0] DCTC_LOWER_WIDTH_ADDR  = 8'h19;
	localparam logic [7:0] DCTC_UPPER_PERIOD_ADDR = 8'h1a;
	localparam logic [7:0] DCTC_UPPER_WIDTH_ADDR  = 8'h1b;
	localparam logic [7:0] DCTC_STATUS_ADDR       = 8'h1c;
	localparam logic [7:0] DCTC_CTRL_RESET   = 8'h00;
	localparam logic [7:0] DCTC_PERIOD_RESET = 8'hff;
	localparam logic [7:0] DCTC_WIDTH_RESET  = 8'hff;
	localparam int DCTC_FF_BIT  = 7;
	localparam int DCTC_SRC_HI  = 6;
	localparam int DCTC_SRC_LO  = 4;
	localparam int DCTC_RUN_BIT = 3;
	localparam int DCTC_MODE_HI = 2;
	localparam int DCTC_MODE_LO = 0;
	// prescaler tap positions: divide by 2^(tap+1)
	localparam int DCTC_PRE_W     = 11;
	localparam int DCTC_TAP_D2048 = 10;
	localparam int DCTC_TAP_D128  = 6;
	localparam int DCTC_TAP_D32   = 4;
	localparam int DCTC_TAP_D8    = 2;
	localparam int DCTC_TAP_D2    = 0;
	localparam int DCTC_LOW_TAP_D8 = 2;
	localparam int DCTC_LOW_PRE_W  = 3;
	typedef enum logic [2:0] {
		DCTC_SRC_SLOW    = 3'h0,
		DCTC_SRC_D128    = 3'h1,
		DCTC_SRC_D32     = 3'h2,
		DCTC_SRC_D8      = 3'h3,
		DCTC_SRC_LOWCLK  = 3'h4,
		DCTC_SRC_D2      = 3'h5,
		DCTC_SRC_HIGHCLK = 3'h6,
		DCTC_SRC_PIN     = 3'h7
	} dctc_src_t;
	typedef enum logic [2:0] {
		DCTC_MODE_TIMER8  = 3'h0,
		DCTC_MODE_DIVOUT  = 3'h1,
		DCTC_MODE_PWM8    = 3'h2,
		DCTC_MODE_CASCADE = 3'h3,
		DCTC_MODE_TIMER16 = 3'h4,
		DCTC_MODE_WARMUP  = 3'h5,
		DCTC_MODE_PWM16   = 3'h6,
		DCTC_MODE_PPG16   = 3'h7
	} dctc_mode_t;
	localparam int DCTC_MODE16_BIT = 2;
endpackage

// ### core/dctc_tick_sel.sv
// one counter's source-clock selector over the shared prescaler edges
`timescale 1ns/1ps
`default_nettype none
module dctc_tick_sel
	import dctc_pkg::*;
(
	input  wire logic [2:0]            sel_in,
	input  wire logic                  slow_tap_in,
	input  wire logic [DCTC_PRE_W-1:0] hi_tick_in,
	input  wire logic                  low_tick_in,
	input  wire logic                  pin_tick_in,
	output logic                       tick_out
);
	// clock-rate edge pulses per code; code 110 counts every system cycle
	always_comb begin
		case (dctc_src_t'(sel_in))
			DCTC_SRC_SLOW:    tick_out = slow_tap_in;
			DCTC_SRC_D128:    tick_out = hi_tick_in[DCTC_TAP_D128];
			DCTC_SRC_D32:     tick_out = hi_tick_in[DCTC_TAP_D32];
			DCTC_SRC_D8:      tick_out = hi_tick_in[DCTC_TAP_D8];
			DCTC_SRC_LOWCLK:  tick_out = low_tick_in;
			DCTC_SRC_D2:      tick_out = hi_tick_in[DCTC_TAP_D2];
			DCTC_SRC_HIGHCLK: tick_out = 1'b1;
			DCTC_SRC_PIN:     tick_out = pin_tick_in;
			default:          tick_out = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ### tb/dctc_assertions.sv
// checker: port-level assertions for the dual timer
`timescale 1ns/1ps
`default_nettype none
module dctc_chk
	import dctc_pkg::*;
#(
	parameter int DATA_W = 8
)(
	input wire logic               clock_in,
	input wire logic               resetn_in,
	input wire logic [DCTC_AW-1:0] addr_in,
	input wire logic [DATA_W-1:0]  wdata_in,
	input wire logic               write_in,
	input wire logic               read_in,
	input wire logic [DATA_W-1:0]  rdata_out,
	input wire logic               lower_match_out,
	input wire logic               lower_flipflop_out,
	input wire logic [DATA_W-1:0]  lower_count_out,
	input wire logic [DATA_W-1:0]  upper_count_out
);
	logic [7:0] lc_reg, uc_reg, lp_reg;
	wire casc = uc_reg[DCTC_MODE16_BIT];
	wire lrun = casc ? uc_reg[DCTC_RUN_BIT] : lc_reg[DCTC_RUN_BIT];
	wire lff = casc ? uc_reg[DCTC_FF_BIT] : lc_reg[DCTC_FF_BIT];
	wire fast = lrun && !casc && lc_reg[6:4] == 3'h6;
	wire known = addr_in < 8'h19 || addr_in > 8'h1c;
	wire [7:0] rd_exp = addr_in == 8'h16 ? lc_reg : addr_in == 8'h17 ? uc_reg :
		addr_in == 8'h18 ? lp_reg : 8'h00;
	// shadow of the two control registers and the lower period register software wrote
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			lc_reg <= 8'h00;
			uc_reg <= 8'h00;
			lp_reg <= 8'hff;
		end else if (write_in) begin
			case (addr_in)
				8'h16: lc_reg <= wdata_in[7:0];
				8'h17: uc_reg <= wdata_in[7:0];
				8'h18: lp_reg <= wdata_in[7:0];
				default: ;
			endcase
		end
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	sequence s_lo_idle;
		(!lrun && $stable(lff)) [*3];
	endsequence
	sequence s_fast;
		(fast && $stable(lc_reg)) [*3] ##0 lower_count_out != 8'h00;
	endsequence
	sequence s_carry;
		casc && $stable(uc_reg) && $changed(upper_count_out);
	endsequence
	a_read_back: assert property (read_in && known |=> rdata_out == $past(rd_exp))
		else $error("bad read data");
	a_stop_lower: assert property (s_lo_idle |-> lower_count_out == 8'h00)
		else $error("lower count not cleared");
	a_stop_upper: assert property (!uc_reg[DCTC_RUN_BIT] [*3] |-> upper_count_out == 8'h00)
		else $error("upper count not cleared");
	a_preset_lower: assert property (s_lo_idle |-> lower_flipflop_out == lff)
		else $error("lower flipflop not at preset");
	a_fast_step: assert property (s_fast |-> lower_count_out == $past(lower_count_out) + 8'h01)
		else $error("lower count missed a clock");
	a_match_due: assert property (fast && lower_count_out == lp_reg |-> ##[1:2] lower_match_out)
		else $error("missing match pulse");
	a_match_zero: assert property (lower_match_out && !casc |-> lower_count_out == 8'h00
		&& $past(lower_count_out) == $past(lp_reg))
		else $error("match without clearing");
	a_carry_wrap: assert property (s_carry |-> lower_count_out == 8'h00)
		else $error("high byte moved without carry");
endmodule
bind dctc_top dctc_chk #(.DATA_W(DATA_W)) chk_u (.*);
`default_nettype wire

// ### tb/tb_dual_cascadable_timer_control.sv
// self-checking bench for the dual cascadable timer
`timescale 1ns/1ps
`default_nettype none
module tb_dual_cascadable_timer_control
	import dctc_pkg::*;
;
	logic       clock_in, resetn_in, write_in, read_in, low_clock_in, lower_pin_in;
	logic       upper_pin_in, divider_option_bit_in, slow_mode_in, lower_match_out;
	logic       upper_match_out, lower_flipflop_out, upper_flipflop_out;
	logic [7:0] addr_in, wdata_in, rdata_out, lower_count_out, upper_count_out;
	int         err_total = 0, check_count = 0, cyc = 0, hits;
	localparam logic [2:0] SRC[9] = '{3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4, 3'h0, 3'h0};
	localparam int WAITS[9] = '{40, 80, 160, 640, 1280, 4096, 160, 384, 384};
	localparam int NUM[9] = '{40, 40, 20, 20, 10, 2, 10, 3, 3};
	dctc_top dut_u (.*);
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	initial begin
		low_clock_in = 1'b0;
		forever #400 low_clock_in = ~low_clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			conclude();
		end
	end
	task automatic chk(input string n, input int lo, input int hi, input logic [7:0] g);
		check_count++;
		if ($isunknown(g) || g < lo || g > hi) begin
			err_total++;
			$display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		write_in <= 1'b1;
		@(posedge clock_in);
		write_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input int e);
		@(posedge clock_in);
		addr_in <= a;
		read_in <= 1'b1;
		@(posedge clock_in);
		read_in <= 1'b0;
		#1 chk("rdata", e, e, rdata_out);
	endtask
	task automatic t_regs();
		for (int a = 'h16; a < 'h1c; a++) begin
			rd(8'(a), a < 'h18 ? 0 : 'hff);
			wr(8'(a), 8'hb0 | 8'(a));
			rd(8'(a), 'hb0 | a);
		end
		wr(8'h30, 8'h5a);
		rd(8'h30, 0);
		wr(8'h16, 8'h00);
		wr(8'h17, 8'h00);
		$display("registers done");
	endtask
	task automatic t_src();
		wr(8'h18, 8'hff);
		for (int i = 0; i < 9; i++) begin
			divider_option_bit_in <= i == 7;
			slow_mode_in <= i == 8;
			wr(8'h16, {1'b0, SRC[i], 4'h8});
			repeat (WAITS[i]) @(posedge clock_in);
			#1 chk("source count", NUM[i] - 2, NUM[i] + 1, lower_count_out);
			wr(8'h16, {1'b0, SRC[i], 4'h0});
		end
		slow_mode_in <= 1'b0;
		wr(8'h16, 8'h78);
		wr(8'h17, 8'h78);
		repeat (12) begin
			lower_pin_in <= ~lower_pin_in;
			upper_pin_in <= ~upper_pin_in;
			repeat (5) @(posedge clock_in);
		end
		repeat (6) @(posedge clock_in);
		#1 chk("pin count", 6, 6, lower_count_out);
		chk("upper pin count", 6, 6, upper_count_out);
		wr(8'h16, 8'h70);
		wr(8'h17, 8'h70);
		$display("sources done");
	endtask
	task automatic t_match();
		wr(8'h18, 8'h05);
		wr(8'h16, 8'h68);
		hits = 0;
		repeat (60) begin
			@(posedge clock_in);
			#1 hits += lower_match_out;
		end
		chk("match pulses", 9, 10, 8'(hits));
		wr(8'h16, 8'h60);
		repeat (2) @(posedge clock_in);
		#1 chk("stopped count", 0, 0, lower_count_out);
		wr(8'h16, 8'he0);
		repeat (3) @(posedge clock_in);
		#1 chk("preset", 1, 1, {7'h00, lower_flipflop_out});
		rd(8'h1c, 5);
		rd(8'h1c, 4);
		wr(8'h1a, 8'h03);
		wr(8'h17, 8'h68);
		hits = 0;
		repeat (40) begin
			@(posedge clock_in);
			#1 hits += upper_match_out;
		end
		chk("upper match pulses", 9, 10, 8'(hits));
		wr(8'h17, 8'h60);
		rd(8'h1c, 6);
		wr(8'h1a, 8'hff);
		$display("match done");
	endtask
	task automatic t_casc();
		wr(8'h16, 8'h63);
		wr(8'h17, 8'h8c);
		repeat (600) @(posedge clock_in);
		#1 chk("upper byte", 2, 2, upper_count_out);
		chk("lower byte", 84, 89, lower_count_out);
		wr(8'h17, 8'h84);
		repeat (2) @(posedge clock_in);
		#1 chk("stopped upper", 0, 0, upper_count_out);
		chk("upper preset", 1, 1, {7'h00, upper_flipflop_out});
		chk("cascade preset", 1, 1, {7'h00, lower_flipflop_out});
		$display("cascade done");
	endtask
	task automatic t_modes();
		wr(8'h16, 8'h03);
		for (int m = 0; m < 8; m++) begin
			wr(8'h17, {5'h0d, 3'(m)});
			repeat (20) @(posedge clock_in);
			#1 chk("mode count", m > 3 ? 0 : 18, m > 3 ? 0 : 21, upper_count_out);
			wr(8'h17, {5'h0c, 3'(m)});
		end
		$display("modes done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		{resetn_in, write_in, read_in, lower_pin_in, upper_pin_in} = 5'h00;
		{divider_option_bit_in, slow_mode_in} = 2'h0;
		{addr_in, wdata_in} = 16'h0000;
		repeat (3) @(posedge clock_in);
		resetn_in <= 1'b1;
		t_regs();
		t_src();
		t_match();
		t_casc();
		t_modes();
		conclude();
	end
endmodule
`default_nettype wire
